//--- src/asr_pkg.sv
package asr_pkg;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_RX_STATUS_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_RX_DATA = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MODE_IRQ = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RX_FLAGS = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_BAUD_DIV_LOW = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_BAUD_DIV_HIGH = 8'h14;

	// receive_status_control fields
	localparam int BIT_SERIAL_PORT_EN = 7;
	localparam int BIT_NINE_BIT_RX_EN = 6;
	localparam int BIT_CONTINUOUS_RX_EN = 4;
	localparam int BIT_ADDR_DETECT_EN = 3;
	localparam int BIT_FRAME_ERR = 2;
	localparam int BIT_OVERRUN_ERR = 1;
	localparam int BIT_RX_NINTH = 0;
	// mode and interrupt-enable fields
	localparam int BIT_CLOCKED_MODE = 0;
	localparam int BIT_RX_IRQ_EN = 1;
	localparam int BIT_PERIPH_IRQ_EN = 2;
	localparam int BIT_GLOBAL_IRQ_EN = 3;
	// flags fields
	localparam int BIT_RX_AVAIL = 0;
	localparam int BIT_RX_IDLE = 1;

	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [15:0] RST_BAUD_DIV = 16'h0000;

	localparam int OVERSAMPLE = 16;
	localparam logic [3:0] TICK_VOTE = 4'h8;
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;
	localparam int FIFO_DEPTH = 2;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_START = 4'b0010,
		ST_DATA = 4'b0100,
		ST_STOP = 4'b1000
	} asr_state_t;

	function automatic logic asr_vote(input logic [2:0] s);
		return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction : asr_vote
endpackage : asr_pkg

//--- src/asr_receiver.sv
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module asr_receiver import asr_pkg::*; (
	input wire logic clock, // 250 MHz clock
	input wire logic rst_n, // Async reset, active low
	input wire logic ce, // Clock enable, freezes all state when low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic rxPin, // Serial receive line
	output logic rxAvailFlag, // Character waiting
	output logic rxIrq // Receive interrupt request
);
	logic [7:0] ctrl_r;
	logic [3:0] modeIrq_r;
	logic [15:0] baudDiv_r;
	logic [15:0] divCnt_r;
	logic tick;
	logic rxMeta_r, rxSync_r, rxPrev_r;
	asr_state_t state_r;
	logic [3:0] tickCnt_r;
	logic [3:0] bitCnt_r;
	logic [2:0] votes_r;
	logic [8:0] rxShiftReg_r;
	logic overrun_r;
	logic [9:0] fifoMem_r [FIFO_DEPTH];
	logic wrPtr_r, rdPtr_r;
	logic [1:0] count_r;
	logic popOk_r;
	logic portEn, rxEn, nineBit, decide, sample, push, pop;
	logic setupPh, accessPh, mapped;
	logic [8:0] newChar;
	logic [9:0] head;
	logic [3:0] bitsWanted;

	assign portEn = ctrl_r[BIT_SERIAL_PORT_EN];
	assign rxEn = ctrl_r[BIT_CONTINUOUS_RX_EN] & ~modeIrq_r[BIT_CLOCKED_MODE]
		& portEn;
	assign nineBit = ctrl_r[BIT_NINE_BIT_RX_EN];
	assign bitsWanted = nineBit ? BITS_NINE : BITS_EIGHT;
	assign setupPh = psel & ~penable;
	assign accessPh = psel & penable;
	assign head = fifoMem_r[rdPtr_r];

	always_comb begin
		case (paddr)
			OFS_RX_STATUS_CONTROL, OFS_RX_DATA, OFS_MODE_IRQ, OFS_RX_FLAGS,
			OFS_BAUD_DIV_LOW, OFS_BAUD_DIV_HIGH: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Zero-wait slave: read data is captured in the setup cycle
	assign pready = accessPh;
	assign pslverr = accessPh & ~mapped;

	// Pin synchroniser; logic uses only the second stage and its delayed copy
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rxMeta_r <= 1'b1;
			rxSync_r <= 1'b1;
			rxPrev_r <= 1'b1;
		end else if (ce) begin
			rxMeta_r <= rxPin;
			rxSync_r <= rxMeta_r;
			rxPrev_r <= rxSync_r;
		end
	end

	// Software registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= RST_CTRL;
			modeIrq_r <= RST_CTRL[3:0];
			baudDiv_r <= RST_BAUD_DIV;
		end else if (ce && accessPh && pwrite) begin
			case (paddr)
				OFS_RX_STATUS_CONTROL: begin
					// Status bits are hardware-owned; only controls store
					ctrl_r[BIT_SERIAL_PORT_EN] <= pwdata[BIT_SERIAL_PORT_EN];
					ctrl_r[BIT_NINE_BIT_RX_EN] <= pwdata[BIT_NINE_BIT_RX_EN];
					ctrl_r[BIT_CONTINUOUS_RX_EN] <= pwdata[BIT_CONTINUOUS_RX_EN];
					ctrl_r[BIT_ADDR_DETECT_EN] <= pwdata[BIT_ADDR_DETECT_EN];
				end
				OFS_MODE_IRQ: modeIrq_r <= pwdata[3:0];
				OFS_BAUD_DIV_LOW: baudDiv_r[7:0] <= pwdata[7:0];
				OFS_BAUD_DIV_HIGH: baudDiv_r[15:8] <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Oversample tick: one per (divisor + 1) clocks
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			divCnt_r <= RST_BAUD_DIV;
		end else if (ce) begin
			if (!portEn || divCnt_r == 16'h0000)
				divCnt_r <= baudDiv_r;
			else
				divCnt_r <= divCnt_r - 16'h0001;
		end
	end
	assign tick = portEn & (divCnt_r == 16'h0000);

	// Decision falls on the tick that completes the three centre samples
	assign decide = tick & (tickCnt_r == TICK_VOTE);
	assign sample = asr_vote({votes_r[1:0], rxSync_r});
	assign newChar = nineBit ? rxShiftReg_r
		: {1'b0, rxShiftReg_r[8:1]};

	// Character complete after stop; drops on overrun or address filter
	always_comb begin
		push = 1'b0;
		if (state_r == ST_STOP && decide && rxEn) begin
			push = 1'b1;
			if (nineBit && ctrl_r[BIT_ADDR_DETECT_EN] && !newChar[8])
				push = 1'b0;
			if (count_r == 2'(FIFO_DEPTH))
				push = 1'b0;
		end
	end

	assign pop = ce & accessPh & ~pwrite & (paddr == OFS_RX_DATA)
		& popOk_r;

	// Recovery state machine
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			tickCnt_r <= 4'h0;
			bitCnt_r <= 4'h0;
			votes_r <= 3'b111;
			rxShiftReg_r <= 9'h000;
		end else if (ce) begin
			if (!rxEn || overrun_r) begin
				// Disabled or overrun: hold off, rearm for a fresh edge
				state_r <= ST_IDLE;
				tickCnt_r <= 4'h0;
			end else begin
				if (tick) begin
					tickCnt_r <= tickCnt_r + 4'h1;
					votes_r <= {votes_r[1:0], rxSync_r};
				end
				case (state_r)
					ST_IDLE: begin
						if (rxPrev_r && !rxSync_r) begin
							state_r <= ST_START;
							tickCnt_r <= 4'h0;
							bitCnt_r <= 4'h0;
						end
					end
					ST_START: begin
						if (decide)
							state_r <= sample ? ST_IDLE : ST_DATA;
					end
					ST_DATA: begin
						if (decide) begin
							// LSB arrives first and walks down to bit 0 in nine-bit mode, to bit 1 in eight-bit mode
							rxShiftReg_r <= {sample, rxShiftReg_r[8:1]};
							bitCnt_r <= bitCnt_r + 4'h1;
							if (bitCnt_r + 4'h1 == bitsWanted)
								state_r <= ST_STOP;
						end
					end
					ST_STOP: begin
						// Framing error does not block the next start
						if (decide)
							state_r <= ST_IDLE;
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// Overrun: set by a character that finds the FIFO full
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			overrun_r <= 1'b0;
		end else if (ce) begin
			if (!rxEn)
				overrun_r <= 1'b0;
			else if (state_r == ST_STOP && decide
				&& count_r == 2'(FIFO_DEPTH))
				overrun_r <= 1'b1;
		end
	end

	// Two-entry FIFO, framing error stored beside each character
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fifoMem_r[0] <= 10'h000;
			fifoMem_r[1] <= 10'h000;
		end else if (ce && push) begin
			fifoMem_r[wrPtr_r] <= {~sample, newChar};
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_r <= 1'b0;
			rdPtr_r <= 1'b0;
			count_r <= 2'h0;
		end else if (ce) begin
			if (!portEn) begin
				wrPtr_r <= 1'b0;
				rdPtr_r <= 1'b0;
				count_r <= 2'h0;
			end else begin
				if (push)
					wrPtr_r <= ~wrPtr_r;
				if (pop)
					rdPtr_r <= ~rdPtr_r;
				if (push && !pop)
					count_r <= count_r + 2'h1;
				else if (pop && !push)
					count_r <= count_r - 2'h1;
			end
		end
	end

	// Read data captured at setup; pop only if something was there then
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
			popOk_r <= 1'b0;
		end else if (ce && setupPh) begin
			prdata <= 32'h0000_0000;
			popOk_r <= 1'b0;
			if (!pwrite) begin
				case (paddr)
					OFS_RX_STATUS_CONTROL: begin
						prdata[BIT_SERIAL_PORT_EN] <= portEn;
						prdata[BIT_NINE_BIT_RX_EN] <= nineBit;
						prdata[BIT_CONTINUOUS_RX_EN] <=
							ctrl_r[BIT_CONTINUOUS_RX_EN];
						prdata[BIT_ADDR_DETECT_EN] <=
							ctrl_r[BIT_ADDR_DETECT_EN];
						// Empty FIFO shows no error: cleared by port off
						prdata[BIT_FRAME_ERR] <= (count_r != 2'h0)
							& head[9];
						prdata[BIT_OVERRUN_ERR] <= overrun_r;
						prdata[BIT_RX_NINTH] <= (count_r != 2'h0)
							& head[8];
					end
					OFS_RX_DATA: begin
						prdata[7:0] <= head[7:0];
						popOk_r <= (count_r != 2'h0);
					end
					OFS_MODE_IRQ: prdata[3:0] <= modeIrq_r;
					OFS_RX_FLAGS: begin
						prdata[BIT_RX_AVAIL] <= rxAvailFlag;
						prdata[BIT_RX_IDLE] <= (state_r == ST_IDLE);
					end
					OFS_BAUD_DIV_LOW: prdata[7:0] <= baudDiv_r[7:0];
					OFS_BAUD_DIV_HIGH: prdata[7:0] <= baudDiv_r[15:8];
					default: ;
				endcase
			end
		end
	end

	// Flag and request registered; framing error never raises a request
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rxAvailFlag <= 1'b0;
			rxIrq <= 1'b0;
		end else if (ce) begin
			rxAvailFlag <= rxEn & (count_next() != 2'h0);
			rxIrq <= rxEn & (count_next() != 2'h0) & modeIrq_r[BIT_RX_IRQ_EN]
				& modeIrq_r[BIT_PERIPH_IRQ_EN]
				& modeIrq_r[BIT_GLOBAL_IRQ_EN];
		end
	end

	function automatic logic [1:0] count_next();
		if (!portEn)
			return 2'h0;
		if (push && !pop)
			return count_r + 2'h1;
		if (pop && !push)
			return count_r - 2'h1;
		return count_r;
	endfunction : count_next
endmodule : asr_receiver

//--- sim/asr_receiver_checker.sv
`timescale 1ns/1ps
module asr_receiver_checker import asr_pkg::*; (
	input wire logic clock, // Clock
	input wire logic rst_n, // Reset
	input wire logic ce, // Clock enable
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [ADDR_W-1:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic rxPin, // Serial line
	input wire logic rxAvailFlag, // Character waiting
	input wire logic rxIrq // Interrupt request
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	AST_READY_ZERO_WAIT: assert property (psel && penable |-> pready)
		else $error("no ready in access cycle");
	AST_READY_ONLY_ACCESS: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	AST_ERR_UNMAPPED: assert property (psel && penable &&
		paddr > OFS_BAUD_DIV_HIGH |-> pslverr)
		else $error("unmapped access not refused");
	AST_ERR_READ_ZERO: assert property (pslverr && !pwrite |-> !prdata)
		else $error("refused read not zero");
	AST_READ_HELD: assert property (psel && penable |=> $stable(prdata))
		else $error("read data moved in access");
	AST_FLAG_READBACK: assert property (psel && penable && !pwrite &&
		paddr == OFS_RX_FLAGS |-> prdata[BIT_RX_AVAIL] == $past(rxAvailFlag))
		else $error("flag readback wrong");
	AST_IRQ_NEEDS_FLAG: assert property (rxIrq |->
		rxAvailFlag || $past(rxAvailFlag))
		else $error("irq without character");
	AST_FLAG_FALL_CAUSE: assert property ($fell(rxAvailFlag) |->
		$past(psel && penable) || $past(psel && penable, 2))
		else $error("flag fell without bus access");
endmodule : asr_receiver_checker

bind asr_receiver asr_receiver_checker asr_receiver_checker_inst (
	.clock(clock), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rxPin(rxPin),
	.rxAvailFlag(rxAvailFlag), .rxIrq(rxIrq));

//--- sim/asr_tx_model.sv
`timescale 1ns/1ps
module asr_tx_model #(parameter int BIT_CLKS = 64) (
	output logic txLine, // Serial line, idles at mark
	input wire logic clock // Bench clock
);
	initial txLine = 1'b1;
	// Start, data, stop, then one idle bit so the receiver can rearm
	task automatic send(input logic [8:0] v, input int n, input logic s);
		for (int i = -1; i <= n + 1; i++) begin
			@(posedge clock);
			txLine <= (i < 0) ? 1'b0 : (i < n) ? v[i] : (i == n) ? s : 1'b1;
			repeat (BIT_CLKS - 1) @(posedge clock);
		end
	endtask : send
	// Low pulse shorter than half a bit: a false start
	task automatic glitch(input int k);
		@(posedge clock);
		txLine <= 1'b0;
		repeat (k) @(posedge clock);
		txLine <= 1'b1;
		repeat (4 * BIT_CLKS) @(posedge clock);
	endtask : glitch
endmodule : asr_tx_model

//--- sim/test_async_serial_receiver.sv
`timescale 1ns/1ps
module test_async_serial_receiver import asr_pkg::*;;
	logic clock, rst_n, psel, penable, pwrite, pslverr, pready, rxPin, e;
	logic rxAvailFlag, rxIrq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [8:0] d[4];
	int num_errors = 0, num_checks = 0, cyc = 0;
	asr_receiver asr_receiver_inst (.clock(clock), .rst_n(rst_n), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxPin(rxPin), .rxAvailFlag(rxAvailFlag), .rxIrq(rxIrq));
	asr_tx_model #(.BIT_CLKS(64)) asr_tx_model_inst (.txLine(rxPin),
		.clock(clock));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic print_verdict();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] v);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clock);
		penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [31:0] st(input logic [7:0] c, input logic [2:0] f);
		return 32'(c | 8'(f));
	endfunction : st
	task automatic snd(input logic [8:0] v, input int n, input logic s);
		asr_tx_model_inst.send(v, n, s);
	endtask : snd
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rst_n = 1'b0;
		void'($urandom(32'hAF34));
		foreach (d[i]) d[i] = 9'($urandom);
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		apb(OFS_RX_STATUS_CONTROL, 1'b0, 0);
		chk(r, 32'h0);
		apb(8'h18, 1'b0, 0);
		chk(32'(e), 32'h1);
		apb(OFS_BAUD_DIV_LOW, 1'b1, 32'h3);
		apb(OFS_BAUD_DIV_LOW, 1'b0, 0);
		chk(r, 32'h3);
		apb(OFS_MODE_IRQ, 1'b1, 32'hE);
		apb(OFS_RX_STATUS_CONTROL, 1'b1, 32'h90);
		$display("test registers done");
		snd(d[0], 8, 1'b1);
		snd(d[1], 8, 1'b1);
		chk(32'(rxIrq), 32'h1);
		apb(OFS_MODE_IRQ, 1'b1, 32'h6);
		repeat (2) @(posedge clock);
		chk(32'(rxIrq), 32'h0);
		chk(32'(rxAvailFlag), 32'h1);
		apb(OFS_MODE_IRQ, 1'b1, 32'hE);
		apb(OFS_RX_DATA, 1'b0, 0);
		chk(32'(r[7:0]), 32'(d[0][7:0]));
		apb(OFS_RX_DATA, 1'b0, 0);
		chk(32'(r[7:0]), 32'(d[1][7:0]));
		apb(OFS_RX_FLAGS, 1'b0, 0);
		chk(32'(r[0]), 32'h0);
		$display("test two characters done");
		snd(d[2], 8, 1'b0);
		snd(d[3], 8, 1'b1);
		apb(OFS_RX_STATUS_CONTROL, 1'b1, 32'h80);
		apb(OFS_RX_STATUS_CONTROL, 1'b0, 0);
		chk(32'(r[7:0]), st(8'h80, 3'b100));
		apb(OFS_RX_STATUS_CONTROL, 1'b1, 32'h90);
		apb(OFS_RX_DATA, 1'b0, 0);
		chk(32'(r[7:0]), 32'(d[2][7:0]));
		apb(OFS_RX_STATUS_CONTROL, 1'b0, 0);
		chk(32'(r[7:0]), st(8'h90, 3'b000));
		apb(OFS_RX_DATA, 1'b0, 0);
		chk(32'(r[7:0]), 32'(d[3][7:0]));
		$display("test framing done");
		for (int i = 0; i < 4; i++)
			snd(d[i], 8, 1'b1);
		apb(OFS_RX_STATUS_CONTROL, 1'b0, 0);
		chk(32'(r[7:0]), st(8'h90, 3'b010));
		for (int i = 0; i < 2; i++) begin
			apb(OFS_RX_DATA, 1'b0, 0);
			chk(32'(r[7:0]), 32'(d[i][7:0]));
		end
		apb(OFS_RX_FLAGS, 1'b0, 0);
		chk(32'(r[0]), 32'h0);
		apb(OFS_RX_STATUS_CONTROL, 1'b1, 32'h80);
		apb(OFS_RX_STATUS_CONTROL, 1'b0, 0);
		chk(32'(r[7:0]), st(8'h80, 3'b000));
		apb(OFS_RX_STATUS_CONTROL, 1'b1, 32'h90);
		$display("test overrun done");
		asr_tx_model_inst.glitch(20);
		apb(OFS_RX_FLAGS, 1'b0, 0);
		chk(32'(r[0]), 32'h0);
		snd(d[3], 8, 1'b1);
		apb(OFS_RX_DATA, 1'b0, 0);
		chk(32'(r[7:0]), 32'(d[3][7:0]));
		snd(d[1], 8, 1'b0);
		apb(OFS_RX_STATUS_CONTROL, 1'b1, 32'h00);
		apb(OFS_RX_STATUS_CONTROL, 1'b1, 32'h90);
		apb(OFS_RX_STATUS_CONTROL, 1'b0, 0);
		chk(32'(r[7:0]), st(8'h90, 3'b000));
		apb(OFS_RX_FLAGS, 1'b0, 0);
		chk(32'(r[0]), 32'h0);
		$display("test start and port reset done");
		apb(OFS_RX_STATUS_CONTROL, 1'b1, 32'hD8);
		snd({1'b0, d[0][7:0]}, 9, 1'b1);
		snd({1'b1, d[2][7:0]}, 9, 1'b1);
		apb(OFS_RX_STATUS_CONTROL, 1'b0, 0);
		chk(32'(r[7:0]), st(8'hD8, 3'b001));
		apb(OFS_RX_DATA, 1'b0, 0);
		chk(32'(r[7:0]), 32'(d[2][7:0]));
		apb(OFS_RX_FLAGS, 1'b0, 0);
		chk(32'(r[0]), 32'h0);
		$display("test nine bit done");
		print_verdict();
	end
endmodule : test_async_serial_receiver
